/* File: common/fupb_pkg.sv */
// constants for the flash user partition base register block
// assumes a 32-bit AXI4-Lite register bus
package fupb_pkg;
    localparam int unsigned addr_w = 8;
    localparam int unsigned data_w = 32;
    // register byte offsets
    localparam logic [7:0] base_off = 8'h00;
    localparam logic [7:0] size_off = 8'h04;
    localparam logic [7:0] stat_off = 8'h08;
    // field layout of the partition base
    localparam int unsigned base_lsb = 11;
    localparam int unsigned base_msb = 19;
    localparam logic [31:0] base_mask = 32'h000FF800;
    localparam logic [31:0] base_reset = 32'h00000000;
    // default flash size, 128 KB
    localparam logic [31:0] flash_size_default = 32'h00020000;
    // status bit positions
    localparam int unsigned stat_user_bit = 0;
    localparam int unsigned stat_over_bit = 1;
    // axi responses
    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;
endpackage

/* File: common/fupb_reg_if.sv */
// register access carrier between bus slave and register file
// assumes one clock shared by both ends
`timescale 1ns/10ps
interface fupb_reg_if;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_err;
    logic [7:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_err;
    modport bus(output wr_en, output wr_addr, output wr_data, output wr_strb,
        input wr_err, output rd_addr, input rd_data, input rd_err);
    modport regs(input wr_en, input wr_addr, input wr_data, input wr_strb,
        output wr_err, input rd_addr, output rd_data, output rd_err);
endinterface

/* File: rtl/fupb_axil_slave.sv */
// AXI4-Lite slave front end
// assumes one write and one read outstanding at most
`timescale 1ns/10ps
module fupb_axil_slave (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    fupb_reg_if.bus rif
);
    import fupb_pkg::*;

    // ****************
    // write channel
    // ****************
    logic aw_have_reg, aw_have_next;
    logic w_have_reg, w_have_next;
    logic [7:0] awaddr_reg, awaddr_next;
    logic [31:0] wdata_reg, wdata_next;
    logic [3:0] wstrb_reg, wstrb_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic awready_reg, awready_next;
    logic wready_reg, wready_next;
    logic do_write;

    // readies are flops so the top's outputs leave straight from a register
    assign awready = awready_reg;
    assign wready = wready_reg;
    assign do_write = aw_have_reg && w_have_reg && !bvalid_reg;
    assign rif.wr_en = do_write;
    assign rif.wr_addr = awaddr_reg;
    assign rif.wr_data = wdata_reg;
    assign rif.wr_strb = wstrb_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;

    always_comb begin
        aw_have_next = aw_have_reg;
        w_have_next = w_have_reg;
        awaddr_next = awaddr_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        if (awvalid && awready) begin
            aw_have_next = 1'b1;
            awaddr_next = awaddr;
        end
        if (wvalid && wready) begin
            w_have_next = 1'b1;
            wdata_next = wdata;
            wstrb_next = wstrb;
        end
        if (do_write) begin
            aw_have_next = 1'b0;
            w_have_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = rif.wr_err ? resp_slverr : resp_okay;
        end else if (bvalid_reg && bready) begin
            bvalid_next = 1'b0;
        end
        awready_next = !aw_have_next && !bvalid_next;
        wready_next = !w_have_next && !bvalid_next;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h00000000;
            wstrb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= 2'h0;
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
        end else begin
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            aw_have_reg <= aw_have_next;
            w_have_reg <= w_have_next;
            awaddr_reg <= awaddr_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
        end
    end

    // ****************
    // read channel
    // ****************
    logic rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;
    logic arready_reg, arready_next;

    assign arready = arready_reg;
    assign rif.rd_addr = araddr;
    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;

    always_comb begin
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (arvalid && arready) begin
            rvalid_next = 1'b1;
            rdata_next = rif.rd_data;
            rresp_next = rif.rd_err ? resp_slverr : resp_okay;
        end else if (rvalid_reg && rready) begin
            rvalid_next = 1'b0;
        end
        arready_next = !rvalid_next;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= 2'h0;
            arready_reg <= 1'b1;
        end else begin
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end
endmodule

/* File: rtl/fupb_regs.sv */
// register file holding the partition base
// assumes strobes from the bus slave, one write per cycle
`timescale 1ns/10ps
module fupb_regs (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] flash_size,
    fupb_reg_if.regs rif,
    output logic [31:0] base_value
);
    import fupb_pkg::*;

    logic [8:0] base_reg, base_next;
    logic [31:0] wr_merged;
    logic [31:0] base_word;

    function automatic logic [31:0] merge_strb(input logic [31:0] old_w,
        input logic [31:0] new_w, input logic [3:0] strb);
        logic [31:0] res;
        res = old_w;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // low and high bits are hard zero
    assign base_word = {12'h000, base_reg, 11'h000};
    assign base_value = base_word;
    assign wr_merged = merge_strb(base_word, rif.wr_data, rif.wr_strb);
    assign rif.wr_err = !(rif.wr_addr == base_off);

    always_comb begin
        base_next = base_reg;
        if (rif.wr_en && rif.wr_addr == base_off) begin
            base_next = wr_merged[base_msb:base_lsb];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            base_reg <= 9'h000;
        end else begin
            base_reg <= base_next;
        end
    end

    always_comb begin
        rif.rd_err = 1'b0;
        if (rif.rd_addr == base_off) begin
            rif.rd_data = base_word;
        end else if (rif.rd_addr == size_off) begin
            rif.rd_data = flash_size;
        end else if (rif.rd_addr == stat_off) begin
            rif.rd_data = 32'h00000000;
            rif.rd_data[stat_user_bit] = (base_word != 32'h00000000);
            rif.rd_data[stat_over_bit] = (base_word > flash_size);
        end else begin
            rif.rd_data = 32'h00000000;
            rif.rd_err = 1'b1;
        end
    end
endmodule

/* File: rtl/fupb_top.sv */
// Contract
// - bits 31..20 read zero and ignore writes
// - bits 19..11 hold the writable user partition base
// - bits 10..0 read zero, base moves in 2 KB steps
// - reset forces the base to zero
// - base zero means all kernel, no user partition
//
// top of the flash user partition base block
// assumes AXI4-Lite master on aclk, flash size given as a static input
`timescale 1ns/10ps
module fupb_top #(
    parameter logic [31:0] flash_size_value = fupb_pkg::flash_size_default
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] user_base,
    output logic user_partition_en,
    output logic base_over_size
);
    import fupb_pkg::*;

    // base moves in 2 KB steps, so a size off that grid cannot be compared fairly
    if (flash_size_value[10:0] != 11'h000) begin : g_size_check
        $error("flash size must be a multiple of 2 KB");
    end

    // ****************
    // instances
    // ****************
    fupb_reg_if rif();
    logic [31:0] base_value;
    logic awready_c, wready_c, arready_c;

    fupb_axil_slave u_slave (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready_c),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready_c),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready_c),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .rif(rif)
    );

    fupb_regs u_regs (
        .aclk(aclk),
        .aresetn(aresetn),
        .flash_size(flash_size_value),
        .rif(rif),
        .base_value(base_value)
    );

    // readies derive from registered state only
    assign awready = awready_c;
    assign wready = wready_c;
    assign arready = arready_c;

    // ****************
    // partition outputs
    // ****************
    logic user_en_next, over_next;
    logic user_en_reg, over_reg;
    logic [31:0] base_out_reg;

    always_comb begin
        user_en_next = (base_value != 32'h00000000);
        // flag only; the write still lands so software sees its mistake
        over_next = (base_value > flash_size_value);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            user_en_reg <= 1'b0;
            over_reg <= 1'b0;
            base_out_reg <= base_reset;
        end else begin
            user_en_reg <= user_en_next;
            over_reg <= over_next;
            base_out_reg <= base_value;
        end
    end

    assign user_partition_en = user_en_reg;
    assign base_over_size = over_reg;
    assign user_base = base_out_reg;
endmodule

/* File: sim/fupb_top_properties.sv */
// port checker for the flash user partition base block
// assumes it is bound onto fupb_top and shares its one clock
`timescale 1ns/10ps
module fupb_top_properties #(
    parameter logic [31:0] flash_size_value = fupb_pkg::flash_size_default
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awready,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic [1:0] bresp,
    input wire logic bready,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic [31:0] rdata,
    input wire logic rready,
    input wire logic [31:0] user_base,
    input wire logic user_partition_en,
    input wire logic base_over_size
);
    import fupb_pkg::*;
    default clocking cb @(posedge aclk); endclocking
    AST_UPPER_ZERO: assert property (disable iff (!aresetn) user_base[31:20] == 12'h000)
        else $error("base upper bits not zero");
    AST_BASE_ON_WRITE: assert property (disable iff (!aresetn)
        !$stable(user_base) |-> $past(bvalid)) else $error("base moved without a write");
    AST_LOW_ZERO: assert property (disable iff (!aresetn) user_base[10:0] == 11'h000)
        else $error("base low bits not zero");
    // the base may be a copy one flop behind, so allow two reset edges
    AST_RESET_ZERO: assert property (!aresetn ##1 !aresetn |=> user_base == 32'h0)
        else $error("base not cleared by reset");
    AST_USER_EN: assert property (disable iff (!aresetn)
        $stable(user_base) |-> user_partition_en == (user_base != 32'h0))
        else $error("user enable wrong");
    AST_OVER_SIZE: assert property (disable iff (!aresetn)
        $stable(user_base) |-> base_over_size == (user_base > flash_size_value))
        else $error("over size flag wrong");
    AST_B_HOLD: assert property (disable iff (!aresetn)
        bvalid && !bready |=> bvalid && $stable(bresp)) else $error("write answer dropped");
    AST_R_HOLD: assert property (disable iff (!aresetn)
        rvalid && !rready |=> rvalid && $stable(rdata)) else $error("read answer dropped");
    AST_AR_READY: assert property (disable iff (!aresetn) arready == !rvalid)
        else $error("arready not inverse of rvalid");
    AST_B_BLOCKS: assert property (disable iff (!aresetn) bvalid |-> !awready && !wready)
        else $error("write taken while answer pending");
    cover property (bvalid && bready && bresp == resp_okay);
    cover property (bvalid && bready && bresp == resp_slverr);
    cover property (rvalid && rready);
    cover property (base_over_size);
endmodule
bind fupb_top fupb_top_properties #(.flash_size_value(flash_size_value)) u_props (.aclk,
    .aresetn, .awready, .wready, .bvalid, .bresp, .bready, .arready, .rvalid, .rdata,
    .rready, .user_base, .user_partition_en, .base_over_size);

/* File: sim/tb_fupb_top.sv */
// self-checking bench for the flash user partition base block
// assumes the port checker is bound from its own file
`timescale 1ns/10ps
module tb_fupb_top;
    import fupb_pkg::*;
    localparam logic [31:0] fsz = 32'h00040000;
    localparam logic [31:0] msk = 32'h000FF800;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, user_partition_en, base_over_size;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, user_base;
    logic [3:0] wstrb = 4'hF;
    logic [1:0] bresp, rresp;
    logic [31:0] vals [5] = '{32'hFFFFFFFF, 32'h00040000, 32'h00040800, 32'h000007FF,
        32'h00100800};
    int num_errors = 0, compares = 0;
    always #4 aclk = ~aclk;
    fupb_top #(.flash_size_value(fsz)) u_fupb_top (.aclk, .aresetn, .awaddr, .awvalid,
        .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .user_base,
        .user_partition_en, .base_over_size);
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask
    // answer channels stall one cycle so the hold logic is exercised
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
        input logic [1:0] er);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) bready <= 1'b1;
        end while (!(bvalid === 1'b1 && bready === 1'b1));
        bready <= 1'b0;
        check({30'h0, bresp}, {30'h0, er});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) rready <= 1'b1;
        end while (!(rvalid === 1'b1 && rready === 1'b1));
        rready <= 1'b0;
        check(rdata, e);
        check({30'h0, rresp}, {30'h0, er});
    endtask
    task automatic outs(input logic [31:0] b);
        repeat (2) @(posedge aclk);
        #1;
        check(user_base, b);
        check({31'h0, user_partition_en}, {31'h0, b != 32'h0});
        check({31'h0, base_over_size}, {31'h0, b > fsz});
        rd(stat_off, {30'h0, b > fsz, b != 32'h0}, resp_okay);
    endtask
    task automatic finish_test;
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ****************
    // main sequence
    // ****************
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd(base_off, 32'h0, resp_okay);
        rd(size_off, fsz, resp_okay);
        outs(32'h0);
        $display("test reset done");
        foreach (vals[i]) begin
            wr(base_off, vals[i], 4'hF, resp_okay);
            rd(base_off, vals[i] & msk, resp_okay);
            outs(vals[i] & msk);
        end
        $display("test field done");
        wr(base_off, 32'hFFFFFFFF, 4'b0100, resp_okay);
        rd(base_off, 32'h000F0800, resp_okay);
        $display("test strobe done");
        wr(size_off, 32'h0, 4'hF, resp_slverr);
        wr(8'h40, 32'hFFFFFFFF, 4'hF, resp_slverr);
        rd(8'h40, 32'h0, resp_slverr);
        rd(base_off, 32'h000F0800, resp_okay);
        $display("test refused done");
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd(base_off, 32'h0, resp_okay);
        outs(32'h0);
        $display("test second reset done");
        finish_test();
    end
    initial begin
        repeat (5000) @(posedge aclk);
        num_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        finish_test();
    end
endmodule
